// *** src/adc_control_consts.vh ***
`ifndef ADC_CONTROL_CONSTS_VH
`define ADC_CONTROL_CONSTS_VH
// register indices
`define REG_CTRL0      3'h0
`define REG_CTRL1      3'h1
`define REG_CTRL2      3'h2
`define REG_RES_HIGH   3'h3
`define REG_RES_LOW    3'h4
`define REG_STATUS     3'h5
// control register 0 fields
`define C0_ENABLE      0
`define C0_GO          1
`define C0_CHAN_LO     2
`define C0_CHAN_HI     6
// control register 1 fields
`define C1_REF_LO      0
`define C1_REF_HI      1
`define C1_CLK_LO      4
`define C1_CLK_HI      6
`define C1_FORMAT      7
// control register 2 fields
`define C2_TRIG_LO     4
`define C2_TRIG_HI     7
// status register fields
`define ST_DONE        0
`define ST_T0FLAG      1
`define ST_T1FLAG      2
// reset value
`define CTRL_RESET     8'h00
// channel codes
`define CH_LAST_EXT    5'h0B
`define CH_TEMP        5'h1D
`define CH_FIXREF      5'h1F
// conversion clock codes
`define CK_DIV2        3'h0
`define CK_DIV4        3'h4
`define CK_DIV8        3'h1
`define CK_DIV16       3'h5
`define CK_DIV32       3'h2
`define CK_DIV64       3'h6
`define CK_RC_MASK     3'h3
// positive reference codes
`define REF_SUPPLY     2'h0
`define REF_PIN        2'h2
// trigger codes
`define TR_NONE        4'h0
`define TR_T0          4'h3
`define TR_T1          4'h4
`define TR_T2          4'h5
`define TR_LC1         4'h8
`define TR_LC2         4'h9
`endif

// *** src/adc_control_result_regs.v ***
// Contract
// - channel codes 0-11 select external inputs
// - codes 29 temperature, 31 fixed reference
// - reserved channel codes connect nothing
// - writing go starts; reads one while busy
// - hardware clears go at conversion end
// - enable bit powers converter; zero disables
// - right format zeroes high byte top
// - left format zeroes low byte bottom
// - clock select divides system clock
// - codes 011 and 111 pick RC clock
// - reference select: supply or pin
// - trigger select maps five sources
// - only rising trigger edges start conversion
// - timer wrap events set own flags
// - left format byte placement of result
// - right format byte placement of result
// - unimplemented control bits read zero
// - end loads result, sets done flag
// - abort during conversion loads partial, fills remaining bits; abort while settling loads nothing
// - done flag set on completed conversions, not on aborts
`timescale 1ns/1ps
`include "adc_control_consts.vh"
module adc_control_result_regs #(
   parameter BITS_PER_CONV = 10,
   parameter SETTLE_TADS   = 1
) (
   input  wire       clk,
   input  wire       arst_n,
   input  wire [2:0] regAddr,
   input  wire [7:0] regWrData,
   input  wire       regWr,
   input  wire       regRd,
   output reg  [7:0] regRdData,
   input  wire       rcClock,
   input  wire       timer0WrapEvent,
   input  wire       timer1WrapEvent,
   input  wire       timer2PeriodHit,
   input  wire       logicCell1Output,
   input  wire       logicCell2Output,
   input  wire       compareHigh,
   output reg        converterOn,
   output reg  [3:0] externalInputSelect,
   output reg        externalInputOn,
   output reg        temperatureOn,
   output reg        fixedReferenceOn,
   output reg        referencePinOn,
   output reg  [9:0] trialCode,
   output reg        sampleHold
);

   // ------------------------------------------------------------
   // reset synchroniser
   // ------------------------------------------------------------
   reg rstMeta_ff;
   reg rstSync_ff;
   wire rst = ~rstSync_ff;

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end
      else
      begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   reg  [5:0] inMeta_ff;
   reg  [5:0] inSync_ff;
   wire [5:0] rawIn = {rcClock, logicCell2Output, logicCell1Output,
                       timer2PeriodHit, timer1WrapEvent,
                       timer0WrapEvent};

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         inMeta_ff <= 6'h00;
         inSync_ff <= 6'h00;
      end
      else
      begin
         inMeta_ff <= rawIn;
         inSync_ff <= inMeta_ff;
      end
   end

   wire t0In  = inSync_ff[0];
   wire t1In  = inSync_ff[1];
   wire t2In  = inSync_ff[2];
   wire lc1In = inSync_ff[3];
   wire lc2In = inSync_ff[4];
   wire rcIn  = inSync_ff[5];

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg        enable_ff;
   reg        go_ff;
   reg [4:0]  chan_ff;
   reg        format_ff;
   reg [2:0]  clkSel_ff;
   reg [1:0]  refSel_ff;
   reg [3:0]  trigSel_ff;
   reg [7:0]  resHigh_ff;
   reg [7:0]  resLow_ff;
   reg        doneFlag_ff;
   reg        t0Flag_ff;
   reg        t1Flag_ff;

   // ------------------------------------------------------------
   // conversion clock tick
   // ------------------------------------------------------------
   reg  [5:0] div_ff;
   reg        rcPrev_ff;
   reg        tick;

   function [5:0] divLast;
      input [2:0] sel;
      begin
         case (sel)
            `CK_DIV2:  divLast = 6'h01;
            `CK_DIV4:  divLast = 6'h03;
            `CK_DIV8:  divLast = 6'h07;
            `CK_DIV16: divLast = 6'h0F;
            `CK_DIV32: divLast = 6'h1F;
            `CK_DIV64: divLast = 6'h3F;
            default:   divLast = 6'h3F;
         endcase
      end
   endfunction

   wire rcSel = ((clkSel_ff & `CK_RC_MASK) == `CK_RC_MASK);

   always @*
   begin
      if (rcSel)
         tick = rcIn & ~rcPrev_ff;
      else
         tick = (div_ff == divLast(clkSel_ff));
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div_ff    <= 6'h00;
         rcPrev_ff <= 1'b0;
      end
      else
      begin
         rcPrev_ff <= rcIn;
         if (!go_ff || tick)
            div_ff <= 6'h00;
         else
            div_ff <= div_ff + 6'h01;
      end
   end

   // ------------------------------------------------------------
   // trigger edge detect
   // ------------------------------------------------------------
   reg trigPrev_ff;
   reg t0Prev_ff;
   reg t1Prev_ff;
   reg trigLevel;

   always @*
   begin
      case (trigSel_ff)
         `TR_T0:  trigLevel = t0In;
         `TR_T1:  trigLevel = t1In;
         `TR_T2:  trigLevel = t2In;
         `TR_LC1: trigLevel = lc1In;
         `TR_LC2: trigLevel = lc2In;
         default: trigLevel = 1'b0;
      endcase
   end

   wire trigRise = trigLevel & ~trigPrev_ff;
   wire t0Rise   = t0In & ~t0Prev_ff;
   wire t1Rise   = t1In & ~t1Prev_ff;

   // ------------------------------------------------------------
   // successive approximation sequencer
   // ------------------------------------------------------------
   localparam ST_IDLE   = 2'b00;
   localparam ST_SETTLE = 2'b01;
   localparam ST_CONV   = 2'b10;
   localparam integer LAST_IDX = BITS_PER_CONV - 1;

   reg [1:0] state_ff;
   reg [3:0] bitIdx_ff;
   reg [3:0] settle_ff;
   reg [9:0] sar_ff;
   reg       lastBit_ff;

   wire wrCtrl0  = regWr && (regAddr == `REG_CTRL0);
   wire swClear  = wrCtrl0 && !regWrData[`C0_GO];
   wire startReq = enable_ff && !go_ff &&
                   ((wrCtrl0 && regWrData[`C0_GO]) || trigRise);
   // comparator follows the registered trial word on this clock;
   // a two-stage delay would leave it stale at divide by 2
   wire decided  = compareHigh;
   wire lastTick = (state_ff == ST_CONV) && tick &&
                   (bitIdx_ff == 4'h0);

   // fill the current bit and all bits below it with the last converted bit
   function [9:0] fillBelow;
      input [9:0] code;
      input [3:0] idx;
      input       fill;
      integer k;
      begin
         fillBelow = code;
         for (k = 0; k < 10; k = k + 1)
            if (k <= idx)
               fillBelow[k] = fill;
      end
   endfunction

   function [15:0] packResult;
      input [9:0] r;
      input       fmt;
      begin
         if (fmt)
            packResult = {6'h00, r};
         else
            packResult = {r, 6'h00};
      end
   endfunction

   wire [9:0] finalCode = {sar_ff[9:1], decided};
   wire [9:0] convCode  = (bitIdx_ff == 4'h0) ? finalCode :
                          fillBelow(sar_ff, bitIdx_ff, lastBit_ff);
   wire abortLoad = go_ff && swClear && (state_ff != ST_IDLE);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff   <= ST_IDLE;
         bitIdx_ff  <= 4'h0;
         settle_ff  <= 4'h0;
         sar_ff     <= 10'h000;
         lastBit_ff <= 1'b0;
         trigPrev_ff <= 1'b0;
         t0Prev_ff  <= 1'b0;
         t1Prev_ff  <= 1'b0;
         resHigh_ff <= `CTRL_RESET;
         resLow_ff  <= `CTRL_RESET;
         doneFlag_ff <= 1'b0;
         t0Flag_ff  <= 1'b0;
         t1Flag_ff  <= 1'b0;
      end
      else
      begin
         trigPrev_ff <= trigLevel;
         t0Prev_ff  <= t0In;
         t1Prev_ff  <= t1In;
         // timer flags: set wins over software clear
         if (t0Rise)
            t0Flag_ff <= 1'b1;
         else if (regWr && regAddr == `REG_STATUS &&
                  regWrData[`ST_T0FLAG])
            t0Flag_ff <= 1'b0;
         if (t1Rise)
            t1Flag_ff <= 1'b1;
         else if (regWr && regAddr == `REG_STATUS &&
                  regWrData[`ST_T1FLAG])
            t1Flag_ff <= 1'b0;
         if (lastTick && !swClear)
            doneFlag_ff <= 1'b1;
         else if (regWr && regAddr == `REG_STATUS &&
                  regWrData[`ST_DONE])
            doneFlag_ff <= 1'b0;
         // result bytes are also software writable
         if (regWr && regAddr == `REG_RES_HIGH)
            resHigh_ff <= regWrData;
         if (regWr && regAddr == `REG_RES_LOW)
            resLow_ff <= regWrData;
         case (state_ff)
            ST_IDLE:
            begin
               if (startReq)
               begin
                  state_ff  <= ST_SETTLE;
                  settle_ff <= 4'h0;
                  sar_ff    <= 10'h200;
                  bitIdx_ff <= LAST_IDX[3:0];
               end
            end
            ST_SETTLE:
            begin
               if (abortLoad || !enable_ff)
                  state_ff <= ST_IDLE;
               else if (tick)
               begin
                  if (settle_ff == SETTLE_TADS - 1)
                     state_ff <= ST_CONV;
                  settle_ff <= settle_ff + 4'h1;
               end
            end
            ST_CONV:
            begin
               if (abortLoad)
               begin
                  {resHigh_ff, resLow_ff} <=
                     packResult(convCode, format_ff);
                  state_ff <= ST_IDLE;
               end
               else if (!enable_ff)
                  state_ff <= ST_IDLE;
               else if (tick)
               begin
                  sar_ff[bitIdx_ff] <= decided;
                  lastBit_ff <= decided;
                  if (bitIdx_ff == 4'h0)
                  begin
                     {resHigh_ff, resLow_ff} <=
                        packResult(finalCode, format_ff);
                     state_ff <= ST_IDLE;
                  end
                  else
                  begin
                     sar_ff[bitIdx_ff - 4'h1] <= 1'b1;
                     bitIdx_ff <= bitIdx_ff - 4'h1;
                  end
               end
            end
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         enable_ff  <= 1'b0;
         go_ff      <= 1'b0;
         chan_ff    <= 5'h00;
         format_ff  <= 1'b0;
         clkSel_ff  <= 3'h0;
         refSel_ff  <= 2'h0;
         trigSel_ff <= 4'h0;
      end
      else
      begin
         if (wrCtrl0)
         begin
            enable_ff <= regWrData[`C0_ENABLE];
            chan_ff   <= regWrData[`C0_CHAN_HI:`C0_CHAN_LO];
         end
         if (regWr && regAddr == `REG_CTRL1)
         begin
            format_ff <= regWrData[`C1_FORMAT];
            clkSel_ff <= regWrData[`C1_CLK_HI:`C1_CLK_LO];
            refSel_ff <= regWrData[`C1_REF_HI:`C1_REF_LO];
         end
         if (regWr && regAddr == `REG_CTRL2)
            trigSel_ff <= regWrData[`C2_TRIG_HI:`C2_TRIG_LO];
         if (startReq)
            go_ff <= 1'b1;
         else if (lastTick || swClear || !enable_ff ||
                  (go_ff && state_ff == ST_IDLE))
            go_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // read port and analog controls
   // ------------------------------------------------------------
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         regRdData           <= 8'h00;
         converterOn         <= 1'b0;
         externalInputSelect <= 4'h0;
         externalInputOn     <= 1'b0;
         temperatureOn       <= 1'b0;
         fixedReferenceOn    <= 1'b0;
         referencePinOn      <= 1'b0;
         trialCode           <= 10'h000;
         sampleHold          <= 1'b0;
      end
      else
      begin
         if (regRd)
         begin
            case (regAddr)
               `REG_CTRL0:
                  regRdData <= {1'b0, chan_ff, go_ff, enable_ff};
               `REG_CTRL1:
                  regRdData <= {format_ff, clkSel_ff, 2'b00,
                                refSel_ff};
               `REG_CTRL2:    regRdData <= {trigSel_ff, 4'h0};
               `REG_RES_HIGH: regRdData <= resHigh_ff;
               `REG_RES_LOW:  regRdData <= resLow_ff;
               `REG_STATUS:
                  regRdData <= {5'h00, t1Flag_ff, t0Flag_ff,
                                doneFlag_ff};
               default:       regRdData <= 8'h00;
            endcase
         end
         else
            regRdData <= 8'h00;
         converterOn <= enable_ff;
         externalInputSelect <= chan_ff[3:0];
         externalInputOn <= enable_ff &&
                            (chan_ff <= `CH_LAST_EXT);
         temperatureOn <= enable_ff && (chan_ff == `CH_TEMP);
         fixedReferenceOn <= enable_ff &&
                             (chan_ff == `CH_FIXREF);
         referencePinOn <= (refSel_ff == `REF_PIN);
         trialCode  <= sar_ff;
         sampleHold <= (state_ff != ST_IDLE);
      end
   end

endmodule // adc_control_result_regs

// *** tb/adc_control_result_regs_properties.sv ***
`timescale 1ns/1ps
module adc_control_result_regs_properties (
   input wire       clk,
   input wire       arst_n,
   input wire [2:0] regAddr,
   input wire [7:0] regWrData,
   input wire       regWr,
   input wire       regRd,
   input wire [7:0] regRdData,
   input wire       timer0WrapEvent,
   input wire       converterOn,
   input wire       externalInputOn,
   input wire       temperatureOn,
   input wire       fixedReferenceOn,
   input wire       sampleHold
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   wire c0Wr = regWr && regAddr == 3'h0;
   wire onWr = c0Wr && regWrData[0];
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_c0_top;
      regRd && regAddr == 3'h0 |=> regRdData[7] == 1'b0;
   endproperty
   a_c0_top: assert property (p_c0_top) else $error("ctrl0 bit 7 set");
   property p_c1_gap;
      regRd && regAddr == 3'h1 |=> regRdData[3:2] == 2'h0;
   endproperty
   a_c1_gap: assert property (p_c1_gap) else $error("ctrl1 gap set");
   property p_c2_gap;
      regRd && regAddr == 3'h2 |=> regRdData[3:0] == 4'h0;
   endproperty
   a_c2_gap: assert property (p_c2_gap) else $error("ctrl2 gap set");
   property p_unmapped;
      regRd && regAddr > 3'h5 |=> regRdData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped data");
   property p_go_busy;
      regRd && regAddr == 3'h0 |=> regRdData[1] == sampleHold;
   endproperty
   a_go_busy: assert property (p_go_busy) else $error("go vs busy");
   property p_chan_excl;
      $onehot0({externalInputOn, temperatureOn, fixedReferenceOn});
   endproperty
   a_chan_excl: assert property (p_chan_excl) else $error("two inputs");
   property p_sel_on;
      (externalInputOn || temperatureOn) |-> converterOn;
   endproperty
   a_sel_on: assert property (p_sel_on) else $error("input while off");
   property p_on_rise;
      $rose(converterOn) |-> $past(onWr) || $past(onWr, 2);
   endproperty
   a_on_rise: assert property (p_on_rise) else $error("enable uncaused");
   property p_go_hold;
      $rose(sampleHold) ##1 (!c0Wr)[*8] |-> sampleHold;
   endproperty
   a_go_hold: assert property (p_go_hold) else $error("conversion short");
   c_done: cover property ($fell(sampleHold));
   c_trig: cover property ($rose(timer0WrapEvent) ##[1:8] $rose(sampleHold));
   c_unmapped: cover property (regRd && regAddr > 3'h5);
endmodule // adc_control_result_regs_properties
bind adc_control_result_regs adc_control_result_regs_properties i_props (
   .clk(clk),
   .arst_n(arst_n),
   .regAddr(regAddr),
   .regWrData(regWrData),
   .regWr(regWr),
   .regRd(regRd),
   .regRdData(regRdData),
   .timer0WrapEvent(timer0WrapEvent),
   .converterOn(converterOn),
   .externalInputOn(externalInputOn),
   .temperatureOn(temperatureOn),
   .fixedReferenceOn(fixedReferenceOn),
   .sampleHold(sampleHold)
);

// *** tb/adc_frontend_model.sv ***
`timescale 1ns/1ps
module adc_frontend_model (
   input  wire [9:0] trialCode,
   input  wire [9:0] level,
   output wire       compareHigh,
   output reg        rcClock
);
   // ----------------------------------------------------------------
   // comparator and rc oscillator
   // ----------------------------------------------------------------
   initial rcClock = 1'b0;
   // rc oscillator runs free, unrelated in phase to clk
   always #61.3 rcClock = ~rcClock;
   // keep the trial bit while the input is at or above the trial word
   assign compareHigh = (level >= trialCode);
endmodule // adc_frontend_model

// *** tb/test_adc_control_result_regs.sv ***
`timescale 1ns/1ps
`include "adc_control_consts.vh"
module test_adc_control_result_regs;
   reg         clk = 1'b0;
   reg         arst_n = 1'b0;
   reg  [2:0]  regAddr = 3'h0;
   reg  [7:0]  regWrData = 8'h00;
   reg         regWr = 1'b0;
   reg         regRd = 1'b0;
   reg  [4:0]  trig = 5'h00;
   reg  [9:0]  level = 10'h000;
   reg  [7:0]  rv;
   reg  [4:0]  code;
   reg  [4:0]  mask;
   reg  [34:0] chans = {5'h00, 5'h0B, 5'h0C, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
   reg  [19:0] trigCodes = {4'h9, 4'h8, 4'h5, 4'h4, 4'h3};
   wire [7:0]  regRdData;
   wire [9:0]  trialCode;
   wire [3:0]  extSel;
   wire        compareHigh, rcClock, converterOn, extOn, tempOn;
   wire        fixOn, refPinOn, sampleHold;
   integer     err_total = 0;
   integer     checks_done = 0;
   integer     i, n, d, lo, hi;
   integer     busyCnt = 0;
   // ----------------------------------------------------------------
   // instances
   // ----------------------------------------------------------------
   adc_control_result_regs i_adc_control_result_regs (
      .clk(clk), .arst_n(arst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .rcClock(rcClock),
      .timer0WrapEvent(trig[0]), .timer1WrapEvent(trig[1]),
      .timer2PeriodHit(trig[2]), .logicCell1Output(trig[3]),
      .logicCell2Output(trig[4]), .compareHigh(compareHigh),
      .converterOn(converterOn), .externalInputSelect(extSel),
      .externalInputOn(extOn), .temperatureOn(tempOn),
      .fixedReferenceOn(fixOn), .referencePinOn(refPinOn),
      .trialCode(trialCode), .sampleHold(sampleHold)
   );
   adc_frontend_model i_adc_frontend_model (
      .trialCode(trialCode), .level(level),
      .compareHigh(compareHigh), .rcClock(rcClock)
   );
   always #2.5 clk = ~clk;
   always @(posedge clk)
      if (sampleHold === 1'b1)
         busyCnt = busyCnt + 1;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task chk(input [15:0] seen, input [15:0] exp);
   begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         err_total = err_total + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task wr(input [2:0] a, input [7:0] v);
   begin
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge clk);
      regWr <= 1'b0;
   end
   endtask
   task rd(input [2:0] a);
   begin
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rv = regRdData;
   end
   endtask
   task wait_idle;
   begin
      n = 0;
      rd(3'h0);
      while (rv[1] !== 1'b0 && n < 2000)
      begin
         rd(3'h0);
         n = n + 1;
      end
      chk(rv[1], 1'b0);
   end
   endtask
   task final_report;
   begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (i = 0; i < 8; i = i + 1)
      begin
         rd(i[2:0]);
         chk(rv, 8'h00);
      end
      wr(3'h1, 8'hFF);
      rd(3'h1);
      chk(rv, 8'hF3);
      wr(3'h2, 8'hFF);
      rd(3'h2);
      chk(rv, 8'hF0);
      wr(3'h6, 8'hFF);
      rd(3'h6);
      chk(rv, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h0, 8'h81); // enable plus unused bit 7, go later
      rd(3'h0);
      chk(rv, 8'h01);
      $display("registers done");
      for (i = 0; i < 7; i = i + 1)
      begin
         code = chans[i*5 +: 5];
         wr(3'h0, {1'b0, code, 2'b01});
         wr(3'h1, {6'h00, i[0], 1'b0});
         repeat (3) @(posedge clk);
         chk(extOn, code <= `CH_LAST_EXT);
         chk(tempOn, code == `CH_TEMP);
         chk(fixOn, code == `CH_FIXREF);
         chk(refPinOn, i[0]);
         chk(converterOn, 1'b1);
         if (code <= `CH_LAST_EXT)
            chk(extSel, code[3:0]);
      end
      wr(3'h0, 8'h00);
      repeat (3) @(posedge clk);
      chk({converterOn, extOn}, 2'b00);
      $display("channels done");
      wr(3'h0, 8'h01);
      repeat (20) @(posedge clk); // acquisition wait
      for (i = 0; i < 16; i = i + 1)
      begin
         n = 10'h2A5 + i * 123;
         level = n[9:0];
         wr(3'h1, {i[3], i[2:0], 4'h0});
         busyCnt = 0;
         wr(3'h0, 8'h03);
         rd(3'h0);
         chk(rv[1], 1'b1);
         wait_idle;
         d = (i[1:0] == 2'h3) ? 0 : (2 << (2 * i[1:0] + i[2]));
         lo = (d == 0) ? 240 : 10 * d;
         hi = (d == 0) ? 285 : 11 * d + 8;
         chk(busyCnt >= lo && busyCnt <= hi, 1'b1);
         rd(3'h3);
         chk(rv, i[3] ? {6'h00, level[9:8]} : level[9:2]);
         rd(3'h4);
         chk(rv, i[3] ? level[7:0] : {level[1:0], 6'h00});
         rd(3'h5);
         chk(rv[0], 1'b1);
         wr(3'h5, 8'h07);
      end
      $display("conversions done");
      level = 10'h1FF;
      wr(3'h1, 8'hE0);
      wr(3'h0, 8'h03);
      repeat (330) @(posedge clk);
      wr(3'h0, 8'h01);
      rd(3'h0);
      chk(rv[1], 1'b0);
      rd(3'h3);
      chk(rv, 8'h01);
      rd(3'h4);
      chk(rv, 8'hFF);
      rd(3'h5);
      chk(rv[0], 1'b0);
      $display("abort done");
      wr(3'h1, 8'h90);
      for (i = 0; i < 5; i = i + 1)
      begin
         mask = (5'h01 << i) | (5'h01 << ((i + 1) % 5));
         wr(3'h2, {trigCodes[i*4 +: 4], 4'h0});
         trig[(i + 1) % 5] <= 1'b1;
         repeat (8) @(posedge clk);
         rd(3'h0);
         chk(rv[1], 1'b0);
         @(posedge clk);
         trig[i] <= 1'b1;
         repeat (6) @(posedge clk);
         rd(3'h0);
         chk(rv[1], 1'b1);
         wait_idle;
         repeat (40) @(posedge clk);
         rd(3'h0);
         chk(rv[1], 1'b0);
         rd(3'h5);
         chk(rv[2:0], {mask[1:0], 1'b1});
         wr(3'h5, 8'h07);
         trig <= 5'h00;
      end
      $display("triggers done");
      final_report;
   end
   initial
   begin
      #400000;
      err_total = err_total + 1;
      final_report;
   end
endmodule // test_adc_control_result_regs
